// ### inc/mps_pkg.sv
// Shared constants and state types for the module power sequencer ends
package mps_pkg;

  // ----------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------
  localparam longint unsigned MPS_CLK_HZ = 64'h2625a00;       // 40 MHz
  localparam longint unsigned MPS_ACT_TIME_S = 64'h32;        // 50 s to activation
  localparam longint unsigned MPS_RST_TIME_S = 64'h1;         // 1 s emergency reset
  localparam longint unsigned MPS_SHUT_TIMEOUT_S = 64'ha;     // 10 s wait for ref drop

  // Least times round up; these are whole numbers of cycles already
  localparam int unsigned MPS_ACT_CYCLES = 32'(MPS_ACT_TIME_S * MPS_CLK_HZ);
  // Strictly longer than the printed time, hence one extra cycle
  localparam int unsigned MPS_RST_CYCLES = 32'(MPS_RST_TIME_S * MPS_CLK_HZ + 64'h1);
  localparam int unsigned MPS_SHUT_CYCLES = 32'(MPS_SHUT_TIMEOUT_S * MPS_CLK_HZ);

  // ----------------------------------------------------------------
  // Reset values of pins
  // ----------------------------------------------------------------
  localparam logic MPS_CARD_OFF_N_RST = 1'b0;
  localparam logic MPS_RST_LINE_RST = 1'b1;

  // ----------------------------------------------------------------
  // State encodings (Gray along the usual path)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MPS_DEV_OFF = 2'h0,
    MPS_DEV_INIT = 2'h1,
    MPS_DEV_ACTIVE = 2'h3,
    MPS_DEV_FINAL = 2'h2
  } mps_dev_state_t;

  typedef enum logic [2:0] {
    MPS_HST_OFF = 3'h0,
    MPS_HST_INIT = 3'h1,
    MPS_HST_ACTIVE = 3'h3,
    MPS_HST_SHUT = 3'h2,
    MPS_HST_RESET = 3'h7
  } mps_hst_state_t;

endpackage

// ### inc/mps_link_if.sv
// Pin-level link between the host controller and the modem module
`timescale 1ns/1ps
interface mps_link_if;
  // Active-low card power control, host driven
  logic card_power_off_n;
  // Open-collector reset: host drive value and enable, resolved line
  logic rst_drv_out;
  logic rst_drv_oe;
  logic system_reset_input_low;
  // Module status outputs
  logic on_state_reference_output;
  logic boot_done;

  // Pull-up on this line; an undriven line reads as released
  assign system_reset_input_low = (rst_drv_oe && !rst_drv_out) ? 1'b0 : 1'b1;

  modport host (
    output card_power_off_n,
    output rst_drv_out,
    output rst_drv_oe,
    input on_state_reference_output,
    input boot_done
  );

  modport dev (
    input card_power_off_n,
    input system_reset_input_low,
    output on_state_reference_output,
    output boot_done
  );
endinterface

// ### core/mps_device.sv
// Modem-side power state tracking: initialization, activation, finalization
`timescale 1ns/1ps
module mps_device #(
  parameter int unsigned ACT_CYCLES = mps_pkg::MPS_ACT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link
  mps_link_if.dev link,
  // User side
  input wire logic shutdown_indication_command_en,
  input wire logic procs_idle,
  output logic cmd_accept,
  output logic full_func,
  output logic finalizing
);
  import mps_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic card_m_r;
  logic card_s_r;
  logic rstl_m_r;
  logic rstl_s_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      card_m_r <= MPS_CARD_OFF_N_RST;
      card_s_r <= MPS_CARD_OFF_N_RST;
      rstl_m_r <= MPS_RST_LINE_RST;
      rstl_s_r <= MPS_RST_LINE_RST;
    end else begin
      card_m_r <= link.card_power_off_n;
      card_s_r <= card_m_r;
      rstl_m_r <= link.system_reset_input_low;
      rstl_s_r <= rstl_m_r;
    end
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  mps_dev_state_t state_r;
  mps_dev_state_t state_nxt;
  logic [31:0] act_cnt_r;
  logic act_done;

  assign act_done = (act_cnt_r == ACT_CYCLES - 32'h1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MPS_DEV_OFF: begin
        if (card_s_r) begin
          state_nxt = MPS_DEV_INIT;
        end
      end
      MPS_DEV_INIT: begin
        if (!card_s_r) begin
          state_nxt = MPS_DEV_FINAL;
        end else if (act_done) begin
          state_nxt = MPS_DEV_ACTIVE;
        end
      end
      MPS_DEV_ACTIVE: begin
        if (!card_s_r) begin
          state_nxt = MPS_DEV_FINAL;
        end
      end
      MPS_DEV_FINAL: begin
        // Ref drops once the active processes have wound down, or at once if the reset line is held low
        if (procs_idle) begin
          state_nxt = MPS_DEV_OFF;
        end
      end
      default: begin
        state_nxt = MPS_DEV_OFF;
      end
    endcase
    // A held reset line restarts the module from scratch
    if (!rstl_s_r) begin
      state_nxt = MPS_DEV_OFF;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= MPS_DEV_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Activation timer runs only while initializing
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      act_cnt_r <= 32'h0;
    end else if (state_r == MPS_DEV_INIT && !act_done) begin
      act_cnt_r <= act_cnt_r + 32'h1;
    end else if (state_r != MPS_DEV_INIT) begin
      act_cnt_r <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic ref_r;
  logic boot_r;
  logic cmd_r;
  logic full_r;
  logic fin_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ref_r <= 1'b0;
      boot_r <= 1'b0;
      cmd_r <= 1'b0;
      full_r <= 1'b0;
      fin_r <= 1'b0;
    end else begin
      ref_r <= (state_nxt != MPS_DEV_OFF);
      boot_r <= shutdown_indication_command_en && (state_nxt == MPS_DEV_ACTIVE);
      // Commands are taken while initializing, but only limited ones
      cmd_r <= (state_nxt == MPS_DEV_INIT) || (state_nxt == MPS_DEV_ACTIVE);
      full_r <= (state_nxt == MPS_DEV_ACTIVE);
      fin_r <= (state_nxt == MPS_DEV_FINAL);
    end
  end

  assign link.on_state_reference_output = ref_r;
  assign link.boot_done = boot_r;
  assign cmd_accept = cmd_r;
  assign full_func = full_r;
  assign finalizing = fin_r;

endmodule

// ### core/mps_host.sv
// Host-side controller for module power-up, graceful shutdown and reset
//
// How it works
// - Host drives card power high to run
// - Reset line stays released during power-up
// - Module activates at least 50 s after power-on
// - Host withholds communication until activation
// - Limited commands accepted while still initializing
// - Boot-done rises after boot when enabled
// - No high levels on pins when off
// - Card power low requests graceful shutdown
// - Module finalizes when card power drops
// - Reference output off means safe to unpower
// - Emergency reset holds line low over 1 s
`timescale 1ns/1ps
module mps_host #(
  parameter int unsigned ACT_CYCLES = mps_pkg::MPS_ACT_CYCLES,
  parameter int unsigned RST_CYCLES = mps_pkg::MPS_RST_CYCLES,
  parameter int unsigned SHUT_CYCLES = mps_pkg::MPS_SHUT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link
  mps_link_if.host link,
  // User requests
  input wire logic power_want,
  input wire logic emergency_reset_req,
  // User status and controls
  output logic supply_en,
  output logic comm_allowed,
  output logic pins_en,
  output logic module_booted,
  output logic shut_timeout,
  output mps_pkg::mps_hst_state_t host_state
);
  import mps_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers for module status pins
  // ----------------------------------------------------------------
  logic ref_m_r;
  logic ref_s_r;
  logic boot_m_r;
  logic boot_s_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ref_m_r <= 1'b0;
      ref_s_r <= 1'b0;
      boot_m_r <= 1'b0;
      boot_s_r <= 1'b0;
    end else begin
      ref_m_r <= link.on_state_reference_output;
      ref_s_r <= ref_m_r;
      boot_m_r <= link.boot_done;
      boot_s_r <= boot_m_r;
    end
  end

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  // A reset request is remembered until the sequencer can act on it,
  // so a one-cycle pulse made during initialization is not dropped.
  logic rst_pend_r;
  mps_hst_state_t state_r;
  mps_hst_state_t state_nxt;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rst_pend_r <= 1'b0;
    end else if (emergency_reset_req) begin
      rst_pend_r <= 1'b1;
    end else if (state_nxt == MPS_HST_RESET || state_nxt == MPS_HST_OFF) begin
      rst_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [31:0] cnt_r;
  logic act_time_up;
  logic rst_time_up;
  logic shut_time_up;

  assign act_time_up = (cnt_r >= ACT_CYCLES - 32'h1);
  assign rst_time_up = (cnt_r == RST_CYCLES - 32'h1);
  assign shut_time_up = (cnt_r == SHUT_CYCLES - 32'h1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MPS_HST_OFF: begin
        if (power_want) begin
          state_nxt = MPS_HST_INIT;
        end
      end
      MPS_HST_INIT: begin
        if (!power_want) begin
          state_nxt = MPS_HST_SHUT;
        end else if (act_time_up && ref_s_r) begin
          // Activation is never earlier than the 50 s mark
          state_nxt = MPS_HST_ACTIVE;
        end
      end
      MPS_HST_ACTIVE: begin
        if (!power_want) begin
          state_nxt = MPS_HST_SHUT;
        end else if (rst_pend_r) begin
          // Emergency use only; never during power-up
          state_nxt = MPS_HST_RESET;
        end
      end
      MPS_HST_SHUT: begin
        if (!ref_s_r || shut_time_up) begin
          state_nxt = MPS_HST_OFF;
        end
      end
      MPS_HST_RESET: begin
        if (rst_time_up) begin
          state_nxt = MPS_HST_INIT;
        end
      end
      default: begin
        state_nxt = MPS_HST_OFF;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= MPS_HST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // One counter serves every timed state; it restarts on each entry
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 32'h0;
    end else if (state_nxt != state_r) begin
      cnt_r <= 32'h0;
    end else if (!act_time_up || state_r != MPS_HST_INIT) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic card_r;
  logic rst_oe_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      card_r <= MPS_CARD_OFF_N_RST;
    end else begin
      // High for as long as the module should run; low asks for shutdown
      card_r <= (state_nxt == MPS_HST_INIT) || (state_nxt == MPS_HST_ACTIVE) ||
                (state_nxt == MPS_HST_RESET);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rst_oe_r <= 1'b0;
    end else begin
      // Open collector: pull low only, never drive high
      rst_oe_r <= (state_nxt == MPS_HST_RESET);
    end
  end

  assign link.card_power_off_n = card_r;
  assign link.rst_drv_out = 1'b0;
  assign link.rst_drv_oe = rst_oe_r;

  // ----------------------------------------------------------------
  // User-side status
  // ----------------------------------------------------------------
  logic supply_r;
  logic comm_r;
  logic pins_r;
  logic booted_r;
  logic tmo_r;
  mps_hst_state_t state_out_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      supply_r <= 1'b0;
      comm_r <= 1'b0;
      pins_r <= 1'b0;
      booted_r <= 1'b0;
      state_out_r <= MPS_HST_OFF;
    end else begin
      // Supply stays on until the ref drops or the wait times out
      supply_r <= (state_nxt != MPS_HST_OFF);
      comm_r <= (state_nxt == MPS_HST_ACTIVE);
      // Digital pins are held low outside a settled on state
      pins_r <= (state_nxt == MPS_HST_ACTIVE) && ref_s_r;
      booted_r <= boot_s_r && (state_nxt == MPS_HST_ACTIVE);
      state_out_r <= state_nxt;
    end
  end

  // Sticky until the next power-up attempt, so software can see it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tmo_r <= 1'b0;
    end else if (state_r == MPS_HST_SHUT && ref_s_r && shut_time_up) begin
      tmo_r <= 1'b1;
    end else if (state_r == MPS_HST_OFF && power_want) begin
      tmo_r <= 1'b0;
    end
  end

  assign supply_en = supply_r;
  assign comm_allowed = comm_r;
  assign pins_en = pins_r;
  assign module_booted = booted_r;
  assign shut_timeout = tmo_r;
  assign host_state = state_out_r;

endmodule

// ### testbench/mps_link_checker.sv
// Link-level assertions for the module power sequencer
`timescale 1ns/1ps
module mps_link_checker #(
  parameter int unsigned ACT_CYCLES = mps_pkg::MPS_ACT_CYCLES,
  parameter int unsigned RST_CYCLES = mps_pkg::MPS_RST_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link
  input wire logic card_power_off_n,
  input wire logic rst_drv_oe,
  input wire logic system_reset_input_low,
  input wire logic on_state_reference_output,
  input wire logic boot_done
);
  logic [31:0] on_cnt_r;
  logic [31:0] oe_cnt_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Run lengths of reference output and reset drive
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      on_cnt_r <= 32'h0;
    end else begin
      on_cnt_r <= on_state_reference_output ? on_cnt_r + 32'h1 : 32'h0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      oe_cnt_r <= 32'h0;
    end else begin
      oe_cnt_r <= rst_drv_oe ? oe_cnt_r + 32'h1 : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ref_rise_a: assert property ($rose(card_power_off_n) && system_reset_input_low
    |-> ##[1:3] on_state_reference_output) else $error("reference output late");
  boot_late_a: assert property ($rose(boot_done) |-> on_cnt_r >= ACT_CYCLES - 1)
    else $error("boot done too early");
  boot_drop_a: assert property ($fell(card_power_off_n) |-> ##[0:3] !boot_done)
    else $error("boot done kept in finalization");
  ref_drop_a: assert property ($fell(on_state_reference_output)
    |-> !$past(card_power_off_n, 2) || !$past(system_reset_input_low, 2))
    else $error("reference dropped without cause");
  rst_len_a: assert property ($fell(rst_drv_oe) |-> oe_cnt_r >= RST_CYCLES)
    else $error("reset pulse too short");
  rst_start_a: assert property ($rose(rst_drv_oe)
    |-> card_power_off_n && on_state_reference_output) else $error("reset during power up");
  boot_ref_a: assert property (boot_done |-> on_state_reference_output)
    else $error("boot done while off");
  card_low_a: assert property ($fell(card_power_off_n) |-> !card_power_off_n [*8])
    else $error("shutdown request not held");
  rst_off_a: assert property (!system_reset_input_low [*5] |-> !on_state_reference_output)
    else $error("module on while reset held");
endmodule

// ### testbench/mps_power_sequencer_bench.sv
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
`define WAITC(cond, lim) for (int w = 0; w < (lim) && !(cond); w++) @(negedge clock);
module mps_power_sequencer_bench;
  import mps_pkg::*;
  // Shortened counts keep the run small
  localparam int unsigned ACT = 40;
  localparam int unsigned RST = 9;
  localparam int unsigned SHUT = 100;
  logic clock;
  logic sys_rst;
  logic power_want;
  logic emergency_reset_req;
  logic shutdown_indication_command_en;
  logic procs_idle;
  logic cmd_accept, full_func, finalizing;
  logic supply_en, comm_allowed, pins_en, module_booted, shut_timeout;
  mps_hst_state_t host_state;
  int errors = 0;
  int total_checks = 0;

  mps_link_if link();
  mps_host #(.ACT_CYCLES(ACT), .RST_CYCLES(RST), .SHUT_CYCLES(SHUT)) u_mps_host (
    .clock(clock), .sys_rst(sys_rst), .link(link), .power_want(power_want),
    .emergency_reset_req(emergency_reset_req), .supply_en(supply_en),
    .comm_allowed(comm_allowed), .pins_en(pins_en), .module_booted(module_booted),
    .shut_timeout(shut_timeout), .host_state(host_state));
  mps_device #(.ACT_CYCLES(ACT)) u_mps_device (
    .clock(clock), .sys_rst(sys_rst), .link(link),
    .shutdown_indication_command_en(shutdown_indication_command_en),
    .procs_idle(procs_idle), .cmd_accept(cmd_accept), .full_func(full_func),
    .finalizing(finalizing));
  mps_link_checker #(.ACT_CYCLES(ACT), .RST_CYCLES(RST)) u_mps_link_checker (
    .clock(clock), .sys_rst(sys_rst), .card_power_off_n(link.card_power_off_n),
    .rst_drv_oe(link.rst_drv_oe), .system_reset_input_low(link.system_reset_input_low),
    .on_state_reference_output(link.on_state_reference_output), .boot_done(link.boot_done));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic summarize();
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic power_up(input logic en);
    int n;
    shutdown_indication_command_en = en;
    power_want = 1'b1;
    `WAITC(host_state === MPS_HST_INIT, 4)
    `CHK("card", 1'b1, link.card_power_off_n)
    `CHK("rst_line", 1'b1, link.system_reset_input_low)
    `WAITC(link.on_state_reference_output === 1'b1, 6)
    `CHK("ref_on", 1'b1, link.on_state_reference_output)
    `CHK("cmd_accept", 1'b1, cmd_accept)
    `CHK("full_early", 1'b0, full_func)
    `CHK("comm_early", 1'b0, comm_allowed)
    `CHK("pins_early", 1'b0, pins_en)
    n = 0;
    while (full_func !== 1'b1 && n < ACT + 20) begin
      @(negedge clock);
      n++;
    end
    `CHK("act_time", 1'b1, n >= ACT - 1 && n < ACT + 20)
    `CHK("boot_done", en, link.boot_done)
    `WAITC(comm_allowed === 1'b1, 6)
    repeat (3) @(negedge clock);
    `CHK("comm", 1'b1, comm_allowed)
    `CHK("pins", 1'b1, pins_en)
    `CHK("booted", en, module_booted)
  endtask

  task automatic early_abort();
    power_want = 1'b1;
    `WAITC(link.on_state_reference_output === 1'b1, 8)
    // A reset asked for mid power-up has to wait for the active state
    emergency_reset_req = 1'b1;
    @(negedge clock);
    emergency_reset_req = 1'b0;
    repeat (4) @(negedge clock);
    `CHK("rst_deferred", 1'b0, link.rst_drv_oe)
    `CHK("rst_line_up", 1'b1, link.system_reset_input_low)
    `CHK("init_held", MPS_HST_INIT, host_state)
    `CHK("init_limited", 1'b0, full_func)
    `CHK("init_comm", 1'b0, comm_allowed)
    // Shutdown while still initializing also drops the pending reset
    power_want = 1'b0;
    procs_idle = 1'b1;
    `WAITC(finalizing === 1'b1, 6)
    `CHK("init_final", 1'b1, finalizing)
    `CHK("init_card_low", 1'b0, link.card_power_off_n)
    `WAITC(host_state === MPS_HST_OFF, 6)
    `CHK("abort_ref_off", 1'b0, link.on_state_reference_output)
    `CHK("abort_off", MPS_HST_OFF, host_state)
    `CHK("abort_no_rst", 1'b0, link.rst_drv_oe)
    procs_idle = 1'b0;
  endtask

  task automatic shutdown(input logic idle_late);
    power_want = 1'b0;
    `WAITC(host_state === MPS_HST_SHUT, 4)
    `CHK("card_low", 1'b0, link.card_power_off_n)
    `CHK("pins_off", 1'b0, pins_en)
    `WAITC(finalizing === 1'b1, 6)
    `CHK("finalizing", 1'b1, finalizing)
    `CHK("full_off", 1'b0, full_func)
    `CHK("boot_off", 1'b0, link.boot_done)
    `CHK("ref_kept", 1'b1, link.on_state_reference_output)
    if (idle_late) begin
      // Module never finishes: host must give up on its own
      repeat (SHUT + 4) @(negedge clock);
      `CHK("timeout_off", MPS_HST_OFF, host_state)
      `CHK("supply_cut", 1'b0, supply_en)
      `CHK("ref_still", 1'b1, link.on_state_reference_output)
    end
    procs_idle = 1'b1;
    `WAITC(link.on_state_reference_output === 1'b0, 4)
    `CHK("ref_off", 1'b0, link.on_state_reference_output)
    `WAITC(host_state === MPS_HST_OFF, 4)
    `CHK("host_off", MPS_HST_OFF, host_state)
    `CHK("supply_off", 1'b0, supply_en)
    `CHK("timeout_flag", idle_late, shut_timeout)
    `CHK("cmd_off", 1'b0, cmd_accept)
    procs_idle = 1'b0;
  endtask

  task automatic emergency();
    int n;
    emergency_reset_req = 1'b1;
    @(negedge clock);
    emergency_reset_req = 1'b0;
    `WAITC(link.rst_drv_oe === 1'b1, 3)
    `CHK("host_rst", MPS_HST_RESET, host_state)
    `CHK("rst_low", 1'b0, link.system_reset_input_low)
    n = 0;
    while (link.rst_drv_oe === 1'b1 && n < RST + 10) begin
      @(negedge clock);
      n++;
    end
    `CHK("rst_len", 1'b1, n >= RST && n < RST + 10)
    `CHK("ref_reset", 1'b0, link.on_state_reference_output)
    `WAITC(full_func === 1'b1, ACT + 20)
    `CHK("reactive", 1'b1, full_func)
  endtask

  initial begin
    sys_rst = 1'b1;
    power_want = 1'b0;
    emergency_reset_req = 1'b0;
    shutdown_indication_command_en = 1'b0;
    procs_idle = 1'b0;
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    `CHK("rst_card", 1'b0, link.card_power_off_n)
    `CHK("rst_ref", 1'b0, link.on_state_reference_output)
    `CHK("rst_host", MPS_HST_OFF, host_state)
    early_abort();
    power_up(1'b1);
    shutdown(1'b0);
    power_up(1'b0);
    emergency();
    shutdown(1'b1);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    summarize();
  end
endmodule
